//--- pic_pkg.sv
// Constants, register map and carrier types for the interrupt controller.
package pic_pkg;

	// Source counts.
	localparam int NUM_INT   = 64;
	localparam int NUM_EXT   = 4;
	localparam int GRP_SIZE  = 8;
	localparam int NUM_IGRP  = 4;
	localparam int NUM_MGRP  = 2;
	localparam int MIX_INT   = 4;

	// Vector numbering: internal sources 0..63 take vectors 64..127, external 0..3 take 48..51.
	localparam logic [6:0] VEC_INT_BASE = 7'h40;
	localparam logic [6:0] VEC_EXT_BASE = 7'h30;
	localparam logic [6:0] VEC_NONE     = 7'h00;

	// Register byte offsets.
	localparam logic [7:0] OFF_GCFG   = 8'h00;
	localparam logic [7:0] OFF_RVEC   = 8'h04;
	localparam logic [7:0] OFF_IPND_H = 8'h08;
	localparam logic [7:0] OFF_IPND_L = 8'h0c;
	localparam logic [7:0] OFF_IMSK_H = 8'h20;
	localparam logic [7:0] OFF_IMSK_L = 8'h24;
	localparam logic [7:0] OFF_EPND   = 8'h2c;
	localparam logic [7:0] OFF_EMSK   = 8'h38;
	localparam logic [7:0] OFF_ECTL   = 8'h3c;
	localparam logic [7:0] OFF_CVEC   = 8'h60;
	localparam logic [7:0] OFF_SVEC   = 8'h64;
	localparam logic [7:0] OFF_TYPE   = 8'h68;
	localparam logic [7:0] OFF_MODE   = 8'h6c;

	// Global configuration and external register fields, bit 31 first in the printed numbering.
	localparam int GC_TOP_LSB  = 24;
	localparam int GC_MIXED_GROUP_B_SOURCE     = 22;
	localparam int GC_MIXA     = 21;
	localparam int GC_IGRP_LSB = 16;
	localparam int GC_TYPE_LSB = 8;
	localparam int EM_REQ0_MC  = 31;
	localparam int EM_EXT_LSB  = 28;

	// Output type encodings.
	localparam logic [1:0] OT_REGULAR  = 2'h0;
	localparam logic [1:0] OT_SYSMGMT  = 2'h1;
	localparam logic [1:0] OT_CRITICAL = 2'h3;

	// Machine-check delays in system bus clock cycles.
	localparam int MC_INT_DLY = 2;
	localparam int MC_EXT_DLY = 4;

	// Winner of one output type.
	typedef struct packed {
		logic       valid;
		logic [6:0] vec;
	} pic_win_t;

	// Requests to the processor core.
	typedef struct packed {
		logic regular;
		logic critical;
		logic sysmgmt;
		logic mcheck;
	} pic_core_req_t;

endpackage

//--- pic_ctrl.sv
// Programmable interrupt controller with Avalon-MM register slave.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// - Unmasked pending regular source asserts regular request.
// - Critical or sysmgmt sources drive their own outputs.
// - Every unmasked source sets internal or external pending.
// - Vector reads return served source code; the regular vector read returns only bits 5:0.
// - Request 0 machine-check only when enabled.
// - Four active-low input-only external requests.
// - Per-input level or edge sensing, asynchronous.
// - Open-drain active-low machine-check pin in disable mode.
// - Assert two internal, four external cycles.
// - Negate two internal, four external cycles.
// - Two mixed groups, grouped or spread.
// - Four internal groups, grouped or spread.
// - Top two group positions selectable type.
// - One software-chosen source promoted to top.
// - Every source has its own mask.
// - Machine check ignores regular masks.
// - Each source has a distinct vector.
// - Enable mode forwards machine checks and interrupts.
// - Registers stay accessible in disable mode.
// - Top source is seven-bit, changeable live.
// - Scheme bit: zero grouped, one spread.
// - Top type: 00 regular, 11 critical.
// - Regular vector stable while being read.
module pic_ctrl #(
	parameter int NUM_INT = pic_pkg::NUM_INT,
	parameter int NUM_EXT = pic_pkg::NUM_EXT
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   srst,
	// Avalon-MM slave.
	input  wire logic [7:0]             avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	input  wire logic [3:0]             avs_byteenable,
	output logic [31:0]                 avs_readdata,
	output logic                        avs_waitrequest,
	// On-chip sources.
	input  wire logic [NUM_INT-1:0]     int_src,
	input  wire logic [NUM_INT-1:0]     int_mc_src,
	// External request pins, active low.
	input  wire logic [NUM_EXT-1:0]     ext_req_n,
	// Mode strap: high selects core-disable mode.
	input  wire logic                   core_disable,
	// Requests to the core.
	output pic_pkg::pic_core_req_t      core_req,
	// Open-drain machine-check pin.
	output logic                        mc_out_n_o,
	output logic                        mc_out_n_oe
);

	typedef enum logic [1:0] {
		PIC_IDLE = 2'b00,
		PIC_ACK  = 2'b01
	} pic_bus_t;

	pic_bus_t                   bus_state;
	logic [NUM_INT-1:0]         int_mask;
	logic [NUM_EXT-1:0]         ext_mask;
	logic [NUM_EXT-1:0]         ext_edge;
	logic [NUM_EXT-1:0]         ext_edge_pend;
	logic                       req0_mc_en;
	logic [6:0]                 top_src;
	logic [1:0]                 top_type;
	logic                       mix_a_scheme;
	logic                       mix_b_scheme;
	logic [3:0]                 igrp_scheme;
	logic [15:0]                grp_type;
	logic [NUM_EXT-1:0]         sync1;
	logic [NUM_EXT-1:0]         sync2;
	logic [NUM_EXT-1:0]         ext_prev;
	logic [NUM_EXT-1:0]         ext_level;
	logic [NUM_EXT-1:0]         ext_pend;
	logic [NUM_INT-1:0]         int_pend;
	logic [NUM_INT-1:0]         int_mc_d1;
	logic [NUM_EXT-1:0]         ext_mc_d1;
	logic                       mc_any;
	pic_pkg::pic_win_t          win_reg;
	pic_pkg::pic_win_t          win_crit;
	pic_pkg::pic_win_t          win_smi;
	logic [6:0]                 rvec;
	logic [6:0]                 cvec;
	logic [6:0]                 svec;
	logic                       rd_hold;
	logic [31:0]                next_rdata;
	logic                       acc;

	always_ff @(posedge clk) begin
		if (srst) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= ~ext_req_n;
			sync2 <= sync1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ext_prev <= '0;
		end else begin
			ext_prev <= sync2;
		end
	end

	assign acc = (avs_read | avs_write) & (bus_state == PIC_ACK);

	// edge latches, cleared by writing one to the external pending bit
	always_ff @(posedge clk) begin
		if (srst) begin
			ext_edge_pend <= '0;
		end else begin
			for (int i = 0; i < NUM_EXT; i++) begin
				if (sync2[i] & ~ext_prev[i]) begin
					ext_edge_pend[i] <= 1'b1;
				end else if (acc & avs_write & (avs_address == pic_pkg::OFF_EPND) &
				             avs_writedata[pic_pkg::EM_EXT_LSB + i]) begin
					ext_edge_pend[i] <= 1'b0;
				end
			end
		end
	end

	// level mode follows the held pin
	assign ext_level = ext_edge & ext_edge_pend | ~ext_edge & sync2;

	// pending set for unmasked requests by origin
	always_ff @(posedge clk) begin
		if (srst) begin
			int_pend <= '0;
			ext_pend <= '0;
		end else begin
			int_pend <= int_src & int_mask;
			ext_pend <= ext_level & ext_mask;
		end
	end

	// Priority position of a source; lower wins.
	function automatic logic [7:0] prio_of(input logic [6:0] vec);
		logic [7:0] p;
		logic [2:0] pos;
		logic [1:0] grp;
		logic       sch;
		p   = 8'hff;
		pos = vec[2:0];
		grp = vec[4:3];
		// promoted source takes the top position
		if (vec == top_src) begin
			p = 8'h00;
		end else if (vec >= pic_pkg::VEC_INT_BASE) begin
			sch = igrp_scheme[grp];
			// eight per group, scheme per group
			p = sch ? {3'h0, pos, 2'h0} + 8'h01 + {6'h0, grp} :
			          8'h01 + {3'h0, grp, pos} + {1'b0, vec[5], 6'h0};
		end else begin
			// mixed groups hold four external sources
			sch = vec[0] ? mix_b_scheme : mix_a_scheme;
			p = sch ? 8'h02 + {4'h0, vec[2:0], 1'b0} : 8'h01;
		end
		return p;
	endfunction

	// Output type of a source.
	function automatic logic [1:0] type_of(input logic [6:0] vec);
		logic [1:0] t;
		t = pic_pkg::OT_REGULAR;
		// top type 00 regular, 11 critical
		if (vec == top_src) begin
			t = top_type;
		// first two positions of each internal group are selectable
		end else if (vec >= pic_pkg::VEC_INT_BASE && vec[2:1] == 2'b00 && !vec[5]) begin
			t = grp_type[{vec[4:3], vec[0], 1'b0} +: 2];
		end
		return t;
	endfunction

	always_comb begin
		logic [7:0] bp [3];
		logic [6:0] v;
		logic [1:0] t;
		v  = '0;
		t  = '0;
		bp = '{8'hff, 8'hff, 8'hff};
		win_reg  = '0;
		win_crit = '0;
		win_smi  = '0;
		for (int i = 0; i < NUM_INT + NUM_EXT; i++) begin
			v = (i < NUM_INT) ? pic_pkg::VEC_INT_BASE + 7'(i) :
			                    pic_pkg::VEC_EXT_BASE + 7'(i - NUM_INT);
			if ((i < NUM_INT) ? int_pend[i] : ext_pend[i - NUM_INT]) begin
				t = type_of(v);
				if (t == pic_pkg::OT_CRITICAL) begin
					if (prio_of(v) < bp[1]) begin
						bp[1] = prio_of(v);
						win_crit = '{1'b1, v};
					end
				end else if (t == pic_pkg::OT_SYSMGMT) begin
					if (prio_of(v) < bp[2]) begin
						bp[2] = prio_of(v);
						win_smi = '{1'b1, v};
					end
				end else if (prio_of(v) < bp[0]) begin
					bp[0] = prio_of(v);
					win_reg = '{1'b1, v};
				end
			end
		end
	end

	// regular vector frozen while a read is in progress
	// vector registers latch the served winners
	always_ff @(posedge clk) begin
		if (srst) begin
			rvec <= pic_pkg::VEC_NONE;
			cvec <= pic_pkg::VEC_NONE;
			svec <= pic_pkg::VEC_NONE;
		end else begin
			if (!rd_hold) begin
				rvec <= win_reg.valid ? win_reg.vec : pic_pkg::VEC_NONE;
			end
			cvec <= win_crit.valid ? win_crit.vec : pic_pkg::VEC_NONE;
			svec <= win_smi.valid ? win_smi.vec : pic_pkg::VEC_NONE;
		end
	end

	// all requests forwarded in core-enable mode
	always_ff @(posedge clk) begin
		if (srst) begin
			core_req <= '0;
		end else begin
			core_req.regular  <= win_reg.valid & ~core_disable;
			core_req.critical <= win_crit.valid & ~core_disable;
			core_req.sysmgmt  <= win_smi.valid & ~core_disable;
			core_req.mcheck   <= mc_any & ~core_disable;
		end
	end

	// internal path two cycles, external path four
	// no regular mask in the path
	// request 0 machine check needs its enable
	always_ff @(posedge clk) begin
		if (srst) begin
			int_mc_d1 <= '0;
			ext_mc_d1 <= '0;
		end else begin
			int_mc_d1 <= int_mc_src;
			ext_mc_d1 <= {{(NUM_EXT-1){1'b0}}, sync2[0] & req0_mc_en};
		end
	end

	assign mc_any = (|int_mc_d1) | (|ext_mc_d1);

	// open-drain low while a machine check is signalled in disable mode
	always_ff @(posedge clk) begin
		if (srst) begin
			mc_out_n_oe <= 1'b0;
		end else begin
			mc_out_n_oe <= core_disable & ((|int_mc_d1) | (|ext_mc_d1));
		end
	end
	assign mc_out_n_o = 1'b0;

	always_ff @(posedge clk) begin
		if (srst) begin
			top_src      <= '0;
			top_type     <= pic_pkg::OT_REGULAR;
			mix_a_scheme <= 1'b0;
			mix_b_scheme <= 1'b0;
			igrp_scheme  <= '0;
			grp_type     <= '0;
			int_mask     <= '0;
			ext_mask     <= '0;
			ext_edge     <= '0;
			req0_mc_en   <= 1'b0;
		end else if (acc & avs_write & (&avs_byteenable)) begin
			case (avs_address)
				pic_pkg::OFF_GCFG: begin
					top_src      <= avs_writedata[pic_pkg::GC_TOP_LSB +: 7];
					mix_b_scheme <= avs_writedata[pic_pkg::GC_MIXED_GROUP_B_SOURCE];
					mix_a_scheme <= avs_writedata[pic_pkg::GC_MIXA];
					igrp_scheme  <= avs_writedata[pic_pkg::GC_IGRP_LSB +: 4];
					top_type     <= avs_writedata[pic_pkg::GC_TYPE_LSB +: 2];
				end
				pic_pkg::OFF_IMSK_H: int_mask[63:32] <= avs_writedata;
				pic_pkg::OFF_IMSK_L: int_mask[31:0]  <= avs_writedata;
				pic_pkg::OFF_EMSK: begin
					req0_mc_en <= avs_writedata[pic_pkg::EM_REQ0_MC];
					ext_mask   <= avs_writedata[pic_pkg::EM_EXT_LSB +: NUM_EXT];
				end
				pic_pkg::OFF_ECTL: ext_edge <= avs_writedata[pic_pkg::EM_EXT_LSB +: NUM_EXT];
				pic_pkg::OFF_TYPE: grp_type <= avs_writedata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		next_rdata = '0;
		case (avs_address)
			pic_pkg::OFF_GCFG: begin
				next_rdata[pic_pkg::GC_TOP_LSB +: 7]  = top_src;
				next_rdata[pic_pkg::GC_MIXED_GROUP_B_SOURCE]          = mix_b_scheme;
				next_rdata[pic_pkg::GC_MIXA]          = mix_a_scheme;
				next_rdata[pic_pkg::GC_IGRP_LSB +: 4] = igrp_scheme;
				next_rdata[pic_pkg::GC_TYPE_LSB +: 2] = top_type;
			end
			pic_pkg::OFF_RVEC:   next_rdata[31:26] = rvec[5:0];
			pic_pkg::OFF_IPND_H: next_rdata = int_pend[63:32];
			pic_pkg::OFF_IPND_L: next_rdata = int_pend[31:0];
			pic_pkg::OFF_IMSK_H: next_rdata = int_mask[63:32];
			pic_pkg::OFF_IMSK_L: next_rdata = int_mask[31:0];
			pic_pkg::OFF_EPND:   next_rdata[pic_pkg::EM_EXT_LSB +: NUM_EXT] = ext_pend;
			pic_pkg::OFF_EMSK: begin
				next_rdata[pic_pkg::EM_REQ0_MC]            = req0_mc_en;
				next_rdata[pic_pkg::EM_EXT_LSB +: NUM_EXT] = ext_mask;
			end
			pic_pkg::OFF_ECTL:   next_rdata[pic_pkg::EM_EXT_LSB +: NUM_EXT] = ext_edge;
			pic_pkg::OFF_CVEC:   next_rdata[31:25] = cvec;
			pic_pkg::OFF_SVEC:   next_rdata[31:25] = svec;
			pic_pkg::OFF_TYPE:   next_rdata[15:0] = grp_type;
			pic_pkg::OFF_MODE:   next_rdata[0] = core_disable;
			default:             next_rdata = '0;
		endcase
	end

	// Bus: first cycle holds waitrequest, second answers.
	always_ff @(posedge clk) begin
		if (srst) begin
			bus_state    <= PIC_IDLE;
			avs_readdata <= '0;
			rd_hold      <= 1'b0;
		end else begin
			case (bus_state)
				PIC_IDLE: begin
					if (avs_read | avs_write) begin
						bus_state <= PIC_ACK;
						rd_hold   <= avs_read & (avs_address == pic_pkg::OFF_RVEC);
						if (avs_read) begin
							avs_readdata <= next_rdata;
						end
					end
				end
				PIC_ACK: begin
					bus_state <= PIC_IDLE;
					rd_hold   <= 1'b0;
				end
				default: bus_state <= PIC_IDLE;
			endcase
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & (bus_state != PIC_ACK);

	// external 0 machine check only with enable
	property p_req0_mc;
		@(posedge clk) disable iff (srst)
		ext_mc_d1[0] |-> $past(req0_mc_en) && $past(sync2[0]);
	endproperty
	a_req0_mc: assert property (p_req0_mc) else $error("mc without enable");

	// pin drives only in disable mode
	property p_od;
		@(posedge clk) disable iff (srst)
		mc_out_n_oe |-> $past(core_disable);
	endproperty
	a_od: assert property (p_od) else $error("pin driven in enable mode");

	// internal assertion reaches pin after two edges
	sequence s_int_rise;
		core_disable && $rose(|int_mc_src) ##1 core_disable;
	endsequence
	property p_int_dly;
		@(posedge clk) disable iff (srst)
		s_int_rise |=> mc_out_n_oe;
	endproperty
	a_int_dly: assert property (p_int_dly) else $error("internal mc delay");

	property p_regular;
		@(posedge clk) disable iff (srst)
		(win_reg.valid && !core_disable) |=> core_req.regular;
	endproperty
	a_regular: assert property (p_regular) else $error("regular request missing");

	property p_mask;
		@(posedge clk) disable iff (srst)
		##1 (int_pend & ~$past(int_mask)) == '0;
	endproperty
	a_mask: assert property (p_mask) else $error("masked source pending");

	property p_rvec_hold;
		@(posedge clk) disable iff (srst)
		rd_hold |=> $stable(rvec);
	endproperty
	a_rvec_hold: assert property (p_rvec_hold) else $error("vector changed in read");

	property p_top;
		@(posedge clk) disable iff (srst)
		(win_reg.valid && top_type == pic_pkg::OT_REGULAR && top_src >= pic_pkg::VEC_INT_BASE
		 && int_pend[top_src[5:0]]) |-> win_reg.vec == top_src;
	endproperty
	a_top: assert property (p_top) else $error("top source lost");

	// machine check ends two cycles after internal source
	sequence s_int_fall;
		core_disable && $fell(|int_mc_src) ##1 core_disable && !(|ext_mc_d1);
	endsequence
	property p_neg;
		@(posedge clk) disable iff (srst)
		s_int_fall |=> !mc_out_n_oe;
	endproperty
	a_neg: assert property (p_neg) else $error("mc negation late");

endmodule

//--- pic_ext_dev.sv
// Model of the external devices that drive the active-low request pins.
`timescale 1ns/1ps
module pic_ext_dev #(
	parameter int DLY = 7
) (
	// Request wishes from the bench.
	input  wire logic [3:0] want,
	// Pins toward the controller.
	output logic      [3:0] ext_req_n
);
	// active low, held
	// A device holds its request until the bench marks it serviced; a released pin is pulled up.
	// The delay keeps pin changes off the controller's clock edges.
	initial ext_req_n = 4'hf;
	always @(want) ext_req_n <= #DLY ~want;
endmodule

//--- tb_programmable_interrupt_controller.sv
// Self-checking testbench for the interrupt controller.
`timescale 1ns/1ps
module tb_programmable_interrupt_controller;
	logic                   clk = 1'b0;
	logic                   srst = 1'b1;
	logic [7:0]             avs_address = 8'h00;
	logic                   avs_read = 1'b0;
	logic                   avs_write = 1'b0;
	logic [31:0]            avs_writedata = 32'h0;
	logic [3:0]             avs_byteenable = 4'hf;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic [63:0]            int_src = 64'h0;
	logic [63:0]            int_mc_src = 64'h0;
	logic [3:0]             want = 4'h0;
	logic [3:0]             ext_req_n;
	logic                   core_disable = 1'b0;
	pic_pkg::pic_core_req_t core_req;
	logic                   mc_out_n_o;
	logic                   mc_out_n_oe;
	wire logic              mc_pin;
	wire logic [4:0]        obs;
	logic [63:0]            exp_q[$];
	logic [63:0]            ent;
	logic [31:0]            rnd;
	int                     fail_count = 0;
	int                     compares = 0;
	int                     seed = 7;
	int                     k;
	int                     w;

	// The open-drain pin is pulled up when nobody drives it.
	assign mc_pin = mc_out_n_oe ? mc_out_n_o : 1'b1;
	assign obs = {core_req.regular, core_req.critical, core_req.sysmgmt, core_req.mcheck, mc_pin};

	always #12.5 clk = ~clk;

	pic_ctrl uut (
		.clk             (clk),
		.srst            (srst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.int_src         (int_src),
		.int_mc_src      (int_mc_src),
		.ext_req_n       (ext_req_n),
		.core_disable    (core_disable),
		.core_req        (core_req),
		.mc_out_n_o      (mc_out_n_o),
		.mc_out_n_oe     (mc_out_n_oe)
	);

	pic_ext_dev dev (
		.want      (want),
		.ext_req_n (ext_req_n)
	);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task give_verdict;
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Holds the request until waitrequest is sampled low, then releases it.
	task bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [3:0] be);
		int n;
		n = 0;
		if (!wr_en) exp_q.push_back({d, m});
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			fail_count++;
			give_verdict();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 4'hf);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, e, m, 4'hf);
	endtask

	// Waits up to lim edges for one observed output to reach v, then compares.
	task waitv(input int i, input logic v, input int lim);
		int n;
		n = 0;
		while (obs[i] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		check(32'(obs[i]), 32'(v));
	endtask

	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Takes the oldest expected read value whenever a read completes.
	always @(posedge clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			ent = exp_q.pop_front();
			check(avs_readdata & ent[31:0], ent[63:32] & ent[31:0]);
		end
	end

	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		k = $unsigned($random(seed)) % 32;
		rd(pic_pkg::OFF_GCFG, 32'h0, 32'hffff_ffff);
		rd(pic_pkg::OFF_RVEC, 32'h0, 32'hffff_ffff);
		wr(8'h70, 32'hffff_ffff);
		rd(8'h70, 32'h0, 32'hffff_ffff);
		bus(1'b1, pic_pkg::OFF_GCFG, 32'h7f00_0300, 32'h0, 4'h3);
		rd(pic_pkg::OFF_GCFG, 32'h0, 32'hffff_ffff);
		int_src <= {$random(seed), $random(seed)} | (64'h1 << k);
		idle(8);
		waitv(4, 1'b0, 0);
		wr(pic_pkg::OFF_IMSK_L, 32'h1 << k);
		waitv(4, 1'b1, 6);
		rd(pic_pkg::OFF_IPND_L, 32'h1 << k, 32'h1 << k);
		int_src <= 64'h0;
		waitv(4, 1'b0, 6);
		for (int t = 0; t < 4; t++) begin
			if (t != 2) begin
				w = (t == 0) ? 4 : ((t == 1) ? 2 : 3);
				wr(pic_pkg::OFF_GCFG, {1'b0, 7'(64 + k), 14'h0, 2'(t), 8'h0});
				int_src[k] <= 1'b1;
				waitv(w, 1'b1, 6);
				check({29'h0, obs[4:2]}, {29'h0, t == 0, t == 3, t == 1});
				int_src[k] <= 1'b0;
				waitv(w, 1'b0, 6);
			end
		end
		wr(pic_pkg::OFF_GCFG, 32'h0);
		wr(pic_pkg::OFF_EMSK, 32'h4000_0000);
		want[2] <= 1'b1;
		waitv(4, 1'b1, 12);
		rd(pic_pkg::OFF_RVEC, {6'(pic_pkg::VEC_EXT_BASE + 7'h2), 26'h0}, 32'hfc00_0000);
		want[2] <= 1'b0;
		waitv(4, 1'b0, 12);
		wr(pic_pkg::OFF_EPND, 32'h4000_0000);
		wr(pic_pkg::OFF_ECTL, 32'h4000_0000);
		idle(2);
		waitv(4, 1'b0, 0);
		want[2] <= 1'b1;
		idle(3);
		want[2] <= 1'b0;
		idle(12);
		waitv(4, 1'b1, 0);
		wr(pic_pkg::OFF_EPND, 32'h4000_0000);
		waitv(4, 1'b0, 6);
		wr(pic_pkg::OFF_IMSK_L, 32'h0);
		int_mc_src[k] <= 1'b1;
		waitv(1, 1'b1, 6);
		check(32'(mc_pin), 32'h1);
		int_mc_src[k] <= 1'b0;
		waitv(1, 1'b0, 6);
		core_disable <= 1'b1;
		rnd = $random(seed);
		wr(pic_pkg::OFF_IMSK_H, rnd);
		rd(pic_pkg::OFF_IMSK_H, rnd, 32'hffff_ffff);
		int_mc_src[32 + k] <= 1'b1;
		waitv(0, 1'b0, 4);
		check({28'h0, obs[4:1]}, 32'h0);
		int_mc_src[32 + k] <= 1'b0;
		waitv(0, 1'b1, 4);
		want[0] <= 1'b1;
		idle(10);
		waitv(0, 1'b1, 0);
		wr(pic_pkg::OFF_EMSK, 32'h8000_0000);
		waitv(0, 1'b0, 8);
		want[0] <= 1'b0;
		waitv(0, 1'b1, 8);
		give_verdict();
	end
endmodule
